// ==== sim/field_model.sv ====
// field side: opto inputs and protection elements from true levels
`timescale 1ns/1ps
module field_model (
  input  wire logic [31:0] lvl,  // wanted level per scheme bit
  output logic      [7:0]  din,  // opto inputs 6..13
  output logic             vbc,  // balance comparator
  output logic             vbp,  // balance protection
  output logic             exc,  // field failure element
  output logic      [13:0] el,   // elements of bits 16..29
  output logic             oc,   // overcurrent element
  output logic             dif   // differential element
);
  // input 13 at bit 0, negations below true forms
  assign din = {lvl[0], lvl[1], lvl[2], lvl[3],
                lvl[5], lvl[7], lvl[9], lvl[11]};
  // balance signals at 12 and 14
  assign vbc = lvl[12];
  assign vbp = lvl[14];
  // elements from bit 15 to 31
  assign exc = lvl[15];
  assign el  = lvl[29:16];
  assign oc  = lvl[30];
  assign dif = lvl[31];
endmodule // field_model

// ==== sim/tb.sv ====
// self-checking bench of the scheme logic matrix
`timescale 1ns/1ps
module tb;
  import scheme_pkg::*;
  logic        clk, rst_b;             // clock, reset
  logic [11:0] awa, ara;               // bus addresses
  logic [31:0] wd, rd, lvl;            // bus data, field levels
  logic [3:0]  ws;                     // byte enables
  logic        awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [1:0]  bres, rres;             // bus answers
  logic [7:0]  din;                    // opto inputs
  logic [13:0] el;                     // element inputs
  logic        vbc, vbp, exc, oc, dif; // single inputs
  logic [14:0] rel;                    // relay contacts
  logic        fe, ae, ti, ai, irq;    // events and flags
  int          n_mismatch, cmp_count;
  int          nf = 0;                 // fault pulses seen
  int          na = 0;                 // alarm pulses seen
  scheme_logic_matrix i_scheme_logic_matrix (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bres), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rres),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .digital_in(din),
    .volt_balance_comparator(vbc), .volt_balance_protection(vbp),
    .excitation_loss_element(exc), .element_in(el),
    .voltage_dependent_overcurrent(oc),
    .generator_differential_element(dif), .relay_out(rel),
    .fault_record_evt(fe), .alarm_record_evt(ae),
    .trip_indication(ti), .alarm_indication(ai), .irq(irq));
  field_model i_field_model (.lvl(lvl), .din(din), .vbc(vbc),
    .vbp(vbp), .exc(exc), .el(el), .oc(oc), .dif(dif));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count one-cycle record pulses
  always @(posedge clk) begin
    if (fe === 1'b1) nf <= nf + 1;
    if (ae === 1'b1) na <= na + 1;
  end
  task report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task setl(input logic [31:0] v);
    @(posedge clk);
    lvl <= v;
  endtask
  // write: address and data together, hold bready until answer
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    // no cycle count assumed: the write response ends a wait, the watchdog ends a hang
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!(bv && br));
    br <= 1'b0;
    chk(bres, e);
  endtask
  task rdw(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rr));
    rr <= 1'b0;
    chk(rd, e);
    chk(rres, er);
  endtask
  task t_reset;
    rdw(OFF_LATCH, 0, RESP_OKAY);
    rdw(OFF_FAULT, 32'h4000, RESP_OKAY);
    rdw(OFF_ALARM, 32'h7FFF, RESP_OKAY);
    rdw(OFF_CTRL, 1, RESP_OKAY);
    rdw(12'h0FC, 0, RESP_SLVERR);
    wr(12'h0FC, 1, RESP_SLVERR);
    // low byte only reaches or word 31, whose line stays idle
    ws <= 4'h1;
    wr(OFF_OR_BASE + 12'h07C, 32'hFFFF, RESP_OKAY);
    ws <= 4'hF;
    rdw(OFF_OR_BASE + 12'h07C, 32'h00FF, RESP_OKAY);
  endtask
  task t_matrix;
    int f0, a0;
    f0 = nf;
    a0 = na;
    wr(OFF_AND_BASE, 32'h8000_0800, RESP_OKAY);
    wr(OFF_OR_BASE, 1, RESP_OKAY);
    setl(32'h0000_0800);
    cyc(4);
    chk(rel, 0);
    setl(32'h8000_0800);
    cyc(4);
    chk(rel, 1);
    chk(na - a0, 1);
    chk(nf - f0, 0);
    rdw(OFF_IND, 2, RESP_OKAY);
    chk({ai, ti}, 2'h2);
    rdw(OFF_OUTS, 1, RESP_OKAY);
    wr(12'h104, 32'h2400, RESP_OKAY);
    wr(12'h184, 32'h4000, RESP_OKAY);
    cyc(4);
    chk(rel, 1);
    setl(0);
    cyc(4);
    chk(rel, 32'h4000);
    chk(nf - f0, 1);
    rdw(OFF_IND, 3, RESP_OKAY);
    chk({ai, ti}, 2'h3);
    setl(32'h4000);
    cyc(4);
    chk(rel, 0);
  endtask
  task t_latch;
    int a0;
    wr(OFF_ALARM, 0, RESP_OKAY);
    wr(OFF_LATCH, 2, RESP_OKAY);
    wr(12'h108, 32'h1000, RESP_OKAY);
    wr(12'h188, 2, RESP_OKAY);
    a0 = na;
    setl(32'h5000);
    cyc(4);
    chk(rel, 2);
    chk(na - a0, 1);
    setl(32'h4000);
    cyc(4);
    chk(rel, 2);
    chk(na - a0, 1);
    wr(OFF_CTRL, 3, RESP_OKAY);
    cyc(4);
    chk(rel, 0);
    rdw(OFF_CTRL, 1, RESP_OKAY);
  endtask
  task t_ff;
    wr(OFF_CTRL, 0, RESP_OKAY);
    wr(12'h10C, 32'h8000, RESP_OKAY);
    wr(12'h18C, 8, RESP_OKAY);
    setl(32'hC000);
    cyc(4);
    chk(rel, 0);
    wr(OFF_CTRL, 1, RESP_OKAY);
    cyc(4);
    chk(rel, 8);
  endtask
  task t_irq;
    chk(irq, 0);
    wr(OFF_IRQ_MASK, 3, RESP_OKAY);
    cyc(3);
    chk(irq, 1);
    rdw(OFF_IRQ_STAT, 3, RESP_OKAY);
    wr(OFF_IRQ_STAT, 3, RESP_OKAY);
    cyc(3);
    chk(irq, 0);
    wr(OFF_IND, 3, RESP_OKAY);
    rdw(OFF_IND, 0, RESP_OKAY);
    chk({ai, ti}, 2'h0);
  endtask
  // main sequence after a three cycle reset
  initial begin
    {rst_b, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, lvl} = '0;
    ws = 4'hF;
    n_mismatch = 0;
    cmp_count = 0;
    cyc(3);
    rst_b <= 1'b1;
    t_reset();
    t_matrix();
    t_latch();
    t_ff();
    t_irq();
    report_and_stop();
  end
  // hang guard, far beyond the under two hundred cycles used
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb

// ==== src/scheme_if.sv ====
// signals passed between the scheme top and its two helpers
`timescale 1ns/1ps
interface scheme_if;
  import scheme_pkg::*;
  logic [31:0]      sig;               // assembled scheme inputs
  logic [31:0]      and_cfg [N_LINE];  // and matrix words
  logic [N_OUT-1:0] or_cfg  [N_LINE];  // or matrix words
  logic [31:0]      line;              // logic line states
  logic [N_OUT-1:0] drive;             // per output drive
  logic [N_OUT-1:0] latch_cfg;         // latching outputs
  logic [N_OUT-1:0] fault_cfg;         // fault trigger outputs
  logic [N_OUT-1:0] alarm_cfg;         // alarm trigger outputs
  logic [N_OUT-1:0] relay;             // operated outputs
  logic             man_reset;         // manual reset pulse
  logic             fault_evt;         // fault record pulse
  logic             alarm_evt;         // alarm record pulse
  modport mat (input sig, and_cfg, or_cfg, output line, drive);
  modport stage (input drive, latch_cfg, fault_cfg, alarm_cfg,
                 man_reset, output relay, fault_evt, alarm_evt);
  modport ctl (output sig, and_cfg, or_cfg, latch_cfg, fault_cfg,
               alarm_cfg, man_reset,
               input line, drive, relay, fault_evt, alarm_evt);
endinterface

// ==== src/scheme_logic_matrix.sv ====
// scheme logic matrix top with its axi4-lite register file
// Contract
// [RULE_01] latch bit set holds output until reset
// [RULE_02] alarm mask is latch or alarm word
// [RULE_03] fault trigger output operating makes fault event
// [RULE_04] fault record raises trip indication everywhere
// [RULE_05] alarm mask output operating makes alarm event
// [RULE_06] alarm record raises alarm indication everywhere
// [RULE_07] config bit 0 is relay 1 upward
// [RULE_08] thirty-two and words connect inputs to lines
// [RULE_09] bits 0-11 digital inputs, negations interleaved
// [RULE_10] bits 12-14 voltage balance signals
// [RULE_11] bits 15-31 protection elements in order
// [RULE_12] thirty-two or words connect lines to outputs
// [RULE_13] disabled field failure feeds inactive signal
// [RULE_14] lines are and, drives are or
// [RULE_15] events fire on rising operated state only
`timescale 1ns/1ps
module scheme_logic_matrix (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [scheme_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [scheme_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [7:0]               digital_in,
  input  wire logic                     volt_balance_comparator,
  input  wire logic                     volt_balance_protection,
  input  wire logic                     excitation_loss_element,
  input  wire logic [13:0]              element_in,
  input  wire logic                     voltage_dependent_overcurrent,
  input  wire logic                     generator_differential_element,
  output logic [scheme_pkg::N_OUT-1:0]  relay_out,
  output logic                          fault_record_evt,
  output logic                          alarm_record_evt,
  output logic                          trip_indication,
  output logic                          alarm_indication,
  output logic                          irq
);
  import scheme_pkg::*;

  scheme_if sif ();

  // configuration
  logic [N_OUT-1:0] latch_reg;            // latching outputs
  logic [N_OUT-1:0] fault_reg;            // fault trigger word
  logic [N_OUT-1:0] alarm_reg;            // alarm trigger word
  logic             ff_en_reg;            // field failure enable
  logic             man_rst_reg;          // one cycle reset pulse
  logic [31:0]      and_reg [N_LINE];     // and matrix words
  logic [N_OUT-1:0] or_reg  [N_LINE];     // or matrix words
  // status
  logic [1:0]       ind_reg;              // trip and alarm indication
  logic [1:0]       ind_next;
  logic [1:0]       irq_stat_reg;         // sticky event bits
  logic [1:0]       irq_stat_next;
  logic [1:0]       irq_mask_reg;         // event enables
  logic             irq_reg;              // interrupt level
  // bus state
  logic             awready_reg;
  logic             wready_reg;
  logic             aw_got_reg;           // address waiting
  logic             w_got_reg;            // data waiting
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             arready_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;
  logic             do_write;             // commit this cycle
  logic [31:0]      rd_data;
  logic             rd_ok;
  logic             wr_ok;

  // byte enables applied to an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // hit in a 32 word matrix window, word aligned
  function automatic logic in_matrix(input logic [ADDR_W-1:0] a,
                                     input logic [11:0] base);
    in_matrix = (a[11:7] == base[11:7]) && (a[1:0] == 2'h0);
  endfunction

  // plain register hit
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [11:0] off);
    is_reg = (a == off);
  endfunction

  // [RULE_09] digital inputs, negations interleaved
  // [RULE_10] voltage balance bits
  // [RULE_11] element order
  always_comb begin
    sif.sig[11:0] = {digital_in[0], ~digital_in[0],
                     digital_in[1], ~digital_in[1],
                     digital_in[2], ~digital_in[2],
                     digital_in[3], ~digital_in[3],
                     digital_in[4], digital_in[5],
                     digital_in[6], digital_in[7]};
    sif.sig[SIG_VB_COMP] = volt_balance_comparator;
    sif.sig[SIG_VB_INV]  = ~volt_balance_protection;
    sif.sig[SIG_VB_PROT] = volt_balance_protection;
    // [RULE_13] enable gates element
    sif.sig[SIG_EXC_LOSS] = excitation_loss_element & ff_en_reg;
    sif.sig[SIG_OC-1:SIG_EXC_LOSS+1] = element_in;
    sif.sig[SIG_OC]   = voltage_dependent_overcurrent;
    sif.sig[SIG_DIFF] = generator_differential_element;
  end

  // configuration toward the helpers
  always_comb begin
    for (int i = 0; i < N_LINE; i++) begin
      sif.and_cfg[i] = and_reg[i];
      sif.or_cfg[i]  = or_reg[i];
    end
    sif.latch_cfg = latch_reg;
    sif.fault_cfg = fault_reg;
    sif.alarm_cfg = alarm_reg;
    sif.man_reset = man_rst_reg;
  end

  scheme_matrix u_matrix (
    .sif (sif)
  );

  scheme_output_stage u_stage (
    .clk   (clk),
    .rst_b (rst_b),
    .sif   (sif)
  );

  // write address and data may come in either order
  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  assign wr_ok = in_matrix(waddr_reg, OFF_AND_BASE)
              || in_matrix(waddr_reg, OFF_OR_BASE)
              || (waddr_reg[11:5] == 7'h00 && waddr_reg[1:0] == 2'h0);

  // write channel handshakes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_got_reg  <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_got_reg  <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // readies return only after the response is taken
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // [RULE_07] bit 0 is relay 1
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_reg <= RST_LATCH;
      fault_reg <= RST_FAULT;
      alarm_reg <= RST_ALARM;
      ff_en_reg <= RST_FF_EN;
      irq_mask_reg <= RST_MASK;
    end else if (do_write) begin
      if (is_reg(waddr_reg, OFF_LATCH))
        latch_reg <= N_OUT'(merge({17'h0, latch_reg}, wdata_reg,
                                  wstrb_reg));
      if (is_reg(waddr_reg, OFF_FAULT))
        fault_reg <= N_OUT'(merge({17'h0, fault_reg}, wdata_reg,
                                  wstrb_reg));
      if (is_reg(waddr_reg, OFF_ALARM))
        alarm_reg <= N_OUT'(merge({17'h0, alarm_reg}, wdata_reg,
                                  wstrb_reg));
      if (is_reg(waddr_reg, OFF_CTRL) && wstrb_reg[0])
        ff_en_reg <= wdata_reg[CTRL_FF_EN];
      if (is_reg(waddr_reg, OFF_IRQ_MASK) && wstrb_reg[0])
        irq_mask_reg <= wdata_reg[1:0];
    end
  end

  // manual reset, a self clearing command bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      man_rst_reg <= 1'b0;
    end else begin
      man_rst_reg <= do_write && is_reg(waddr_reg, OFF_CTRL)
                     && wstrb_reg[0] && wdata_reg[CTRL_MAN_RST];
    end
  end

  // [RULE_08] and word storage
  // [RULE_12] or word storage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < N_LINE; i++) begin
        and_reg[i] <= RST_AND;
        or_reg[i]  <= RST_OR;
      end
    end else if (do_write) begin
      if (in_matrix(waddr_reg, OFF_AND_BASE))
        and_reg[waddr_reg[6:2]] <= merge(and_reg[waddr_reg[6:2]],
                                         wdata_reg, wstrb_reg);
      if (in_matrix(waddr_reg, OFF_OR_BASE))
        or_reg[waddr_reg[6:2]] <= N_OUT'(merge(
          {17'h0, or_reg[waddr_reg[6:2]]}, wdata_reg, wstrb_reg));
    end
  end

  // indications and sticky bits clear by writing one; set wins
  always_comb begin
    ind_next = ind_reg;
    irq_stat_next = irq_stat_reg;
    if (do_write && is_reg(waddr_reg, OFF_IND) && wstrb_reg[0])
      ind_next = ind_reg & ~wdata_reg[1:0];
    if (do_write && is_reg(waddr_reg, OFF_IRQ_STAT) && wstrb_reg[0])
      irq_stat_next = irq_stat_reg & ~wdata_reg[1:0];
    // [RULE_04] fault sets trip
    ind_next[IND_TRIP] = ind_next[IND_TRIP] | sif.fault_evt;
    // [RULE_06] alarm sets alarm
    ind_next[IND_ALARM] = ind_next[IND_ALARM] | sif.alarm_evt;
    irq_stat_next = irq_stat_next | {sif.alarm_evt, sif.fault_evt};
  end

  // status flops and interrupt level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ind_reg      <= 2'h0;
      irq_stat_reg <= 2'h0;
      irq_reg      <= 1'b0;
    end else begin
      ind_reg      <= ind_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // read decode on the live address
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (in_matrix(s_axi_araddr, OFF_AND_BASE))
      rd_data = and_reg[s_axi_araddr[6:2]];
    else if (in_matrix(s_axi_araddr, OFF_OR_BASE))
      rd_data = {17'h0, or_reg[s_axi_araddr[6:2]]};
    else if (is_reg(s_axi_araddr, OFF_LATCH))
      rd_data = {17'h0, latch_reg};
    else if (is_reg(s_axi_araddr, OFF_FAULT))
      rd_data = {17'h0, fault_reg};
    else if (is_reg(s_axi_araddr, OFF_ALARM))
      rd_data = {17'h0, alarm_reg};
    else if (is_reg(s_axi_araddr, OFF_CTRL))
      rd_data = {31'h0, ff_en_reg};
    else if (is_reg(s_axi_araddr, OFF_OUTS))
      rd_data = {17'h0, sif.relay};
    else if (is_reg(s_axi_araddr, OFF_IND))
      rd_data = {30'h0, ind_reg};
    else if (is_reg(s_axi_araddr, OFF_IRQ_STAT))
      rd_data = {30'h0, irq_stat_reg};
    else if (is_reg(s_axi_araddr, OFF_IRQ_MASK))
      rd_data = {30'h0, irq_mask_reg};
    else
      rd_ok = 1'b0;
  end

  // read channel, one read in flight
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_data;
      rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;
  assign relay_out        = sif.relay;
  assign fault_record_evt = sif.fault_evt;
  assign alarm_record_evt = sif.alarm_evt;
  assign trip_indication  = ind_reg[IND_TRIP];
  assign alarm_indication = ind_reg[IND_ALARM];
  assign irq              = irq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_trip_follows: assert property ( // [RULE_04]
    sif.fault_evt |=> trip_indication)
    else $error("trip indication missing after fault record");
  a_alarm_follows: assert property ( // [RULE_06]
    sif.alarm_evt |=> alarm_indication)
    else $error("alarm indication missing after alarm record");
  a_ff_disabled: assert property ( // [RULE_13]
    !ff_en_reg |-> !sif.sig[SIG_EXC_LOSS])
    else $error("disabled field failure reached the matrix");
  a_line_zero_path: assert property ( // [RULE_14]
    (and_reg[0] != 32'h0 && (sif.sig & and_reg[0]) == and_reg[0])
    |-> (sif.drive & or_reg[0]) == or_reg[0])
    else $error("line 0 did not drive its outputs");
  // level lags the mask by one edge, follows the status at once
  a_irq_level: assert property (
    irq == ((irq_stat_reg & $past(irq_mask_reg)) != 2'h0))
    else $error("interrupt level does not match masked status");
endmodule // scheme_logic_matrix

// ==== src/scheme_matrix.sv ====
// and matrix into logic lines, or matrix into output drives
`timescale 1ns/1ps
module scheme_matrix (
  scheme_if.mat sif
);
  import scheme_pkg::*;

  // a line with no connection stays low, else it would fire always
  function automatic logic line_hit(input logic [31:0] s,
                                    input logic [31:0] c);
    line_hit = (c != 32'h0000_0000) && ((s & c) == c);
  endfunction

  // [RULE_08] and matrix lines
  always_comb begin
    for (int i = 0; i < N_LINE; i++) begin
      sif.line[i] = line_hit(sif.sig, sif.and_cfg[i]);
    end
  end

  // [RULE_14] or of lines
  always_comb begin
    sif.drive = '0;
    for (int i = 0; i < N_LINE; i++) begin
      // [RULE_12] line to outputs
      if (sif.line[i]) begin
        sif.drive = sif.drive | sif.or_cfg[i];
      end
    end
  end
endmodule // scheme_matrix

// ==== src/scheme_output_stage.sv ====
// latch stage of the fifteen outputs and record event pulses
`timescale 1ns/1ps
module scheme_output_stage (
  input wire logic clk,
  input wire logic rst_b,
  scheme_if.stage  sif
);
  import scheme_pkg::*;

  logic [N_OUT-1:0] relay_reg;   // operated outputs
  logic [N_OUT-1:0] relay_next;  // next operated state
  logic [N_OUT-1:0] rise;        // outputs newly operated
  logic             fault_reg;   // fault record pulse
  logic             alarm_reg;   // alarm record pulse

  // [RULE_01] latch or follow
  always_comb begin
    relay_next = sif.drive
               | (relay_reg & sif.latch_cfg & ~{N_OUT{sif.man_reset}});
    rise = relay_next & ~relay_reg;
  end

  // operated state, bit 0 is relay 1
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      relay_reg <= '0;
    end else begin
      relay_reg <= relay_next;
    end
  end

  // [RULE_15] edge events only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fault_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      // [RULE_03] fault record event
      fault_reg <= |(rise & sif.fault_cfg);
      // [RULE_02] latch ors alarm
      // [RULE_05] alarm record event
      alarm_reg <= |(rise & (sif.alarm_cfg | sif.latch_cfg));
    end
  end

  assign sif.relay     = relay_reg;
  assign sif.fault_evt = fault_reg;
  assign sif.alarm_evt = alarm_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_settled;
    !sif.man_reset ##1 1'b1;
  endsequence

  a_latch_holds: assert property ( // [RULE_01]
    s_settled |-> (($past(relay_reg) & $past(sif.latch_cfg))
                   & ~relay_reg) == '0)
    else $error("latched output dropped without reset");
  a_self_follow: assert property ( // [RULE_01]
    1'b1 |=> (relay_reg & ~$past(sif.latch_cfg))
             == ($past(sif.drive) & ~$past(sif.latch_cfg)))
    else $error("self reset output not following drive");
  a_fault_event: assert property ( // [RULE_03]
    1'b1 |=> fault_reg == |(relay_reg & ~$past(relay_reg)
                            & $past(sif.fault_cfg)))
    else $error("fault event mismatch");
  a_alarm_event: assert property ( // [RULE_05]
    1'b1 |=> alarm_reg == |(relay_reg & ~$past(relay_reg)
             & ($past(sif.alarm_cfg) | $past(sif.latch_cfg))))
    else $error("alarm event mismatch");
  a_no_repeat: assert property ( // [RULE_15]
    (relay_reg == $past(relay_reg)) |-> !fault_reg && !alarm_reg)
    else $error("event without a rising output");
endmodule // scheme_output_stage

// ==== src/scheme_pkg.sv ====
// constants shared by the scheme logic matrix design
package scheme_pkg;
  // sizes
  localparam int N_OUT  = 15;
  localparam int N_LINE = 32;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFF_LATCH    = 12'h000;
  localparam logic [11:0] OFF_FAULT    = 12'h004;
  localparam logic [11:0] OFF_ALARM    = 12'h008;
  localparam logic [11:0] OFF_CTRL     = 12'h00C;
  localparam logic [11:0] OFF_OUTS     = 12'h010;
  localparam logic [11:0] OFF_IND      = 12'h014;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
  localparam logic [11:0] OFF_AND_BASE = 12'h100;
  localparam logic [11:0] OFF_OR_BASE  = 12'h180;
  // values after reset
  localparam logic [14:0] RST_LATCH = 15'h0000;
  localparam logic [14:0] RST_FAULT = 15'h4000;
  localparam logic [14:0] RST_ALARM = 15'h7FFF;
  localparam logic        RST_FF_EN = 1'b1;
  localparam logic [31:0] RST_AND   = 32'h0000_0000;
  localparam logic [14:0] RST_OR    = 15'h0000;
  localparam logic [1:0]  RST_MASK  = 2'h0;
  // field positions
  localparam int CTRL_FF_EN   = 0;
  localparam int CTRL_MAN_RST = 1;
  localparam int IND_TRIP     = 0;
  localparam int IND_ALARM    = 1;
  // scheme input bit positions
  localparam int SIG_VB_COMP  = 12;
  localparam int SIG_VB_INV   = 13;
  localparam int SIG_VB_PROT  = 14;
  localparam int SIG_EXC_LOSS = 15;
  localparam int SIG_OC       = 30;
  localparam int SIG_DIFF     = 31;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
